//--- logic/data_logging_pkg.sv
package data_logging_pkg;

    // ***************************************************************
    // Sizes
    // ***************************************************************
    localparam int NUM_CH      = 4;
    localparam int DATA_W      = 16;
    localparam int ACC_W       = 32;
    localparam int DIV_W       = 16;
    localparam int ADDR_W      = 30;

    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int CLK_HZ          = 125_000_000;
    localparam int MAX_LOG_RATE_HZ = 1000;
    localparam int RT_RATE_HZ      = 50;
    localparam int TICK_CYCLES     = CLK_HZ / MAX_LOG_RATE_HZ;
    localparam int RT_TICKS        = MAX_LOG_RATE_HZ / RT_RATE_HZ;

    // ***************************************************************
    // Storage capacity in bytes, one 32-bit record per word
    // ***************************************************************
    localparam logic [ADDR_W-1:0] CAP_BASE_BYTES  = ADDR_W'(250 * 1024 * 1024);
    localparam logic [ADDR_W-1:0] CAP_UPGRD_BYTES = ADDR_W'(500 * 1024 * 1024);
    localparam logic [ADDR_W-1:0] REC_BYTES       = 30'h0000_0004;

    // ***************************************************************
    // Register map (word aligned byte addresses)
    // ***************************************************************
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_IRQ     = 8'h08;
    localparam logic [7:0] REG_MASK    = 8'h0C;
    localparam logic [7:0] REG_WPTR    = 8'h10;
    localparam logic [7:0] REG_CH_BASE = 8'h20;
    localparam logic [7:0] REG_RT_BASE = 8'h40;

    // CTRL fields
    localparam int CTRL_START  = 0;
    localparam int CTRL_STOP   = 1;
    localparam int CTRL_CYCLIC = 2;
    localparam int CTRL_UPGRD  = 3;
    localparam int CTRL_CLEAR  = 4;

    // Channel config fields
    localparam int CH_EN       = 31;
    localparam int CH_FILT     = 30;
    localparam int CH_BITS     = 29;
    localparam int CH_RTFILT   = 28;
    localparam logic [31:0] CH_RESET = 32'h4000_0000;
    localparam logic [3:0]  MASK_RESET = 4'h0;

    // Interrupt events
    localparam int EV_FULL     = 0;
    localparam int EV_WRAP     = 1;
    localparam int EV_START    = 2;
    localparam int EV_STOP     = 3;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } sample_t;

    typedef struct packed {
        logic              en;
        logic              filt;
        logic              bits;
        logic              rtFilt;
        logic [DIV_W-1:0]  div;
    } chcfg_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       data;
    } flashwr_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOG,
        ST_HALT
    } logstate_t;

endpackage

//--- logic/data_logging_controller.sv
// Operation
// R1: Samples are written while the start input is true and the stop input is false.
// R2: On full storage logging halts, or in cyclic mode the pointer wraps over the oldest data.
// R3: Software should normally choose cyclic mode.
// R4: Each channel has its own rate divider of a 1000 per second tick.
// R5: A channel records only when a fresh source sample has arrived, never faster than its source.
// R6: Averaging is offered for channels logged below their update rate.
// R7: A filtered record is the mean of all samples since that channel's previous record.
// R8: The filter bit resets to enabled for every channel and can be cleared per channel.
// R9: Channels marked as bit fields are never averaged.
// R10: Channels flagged for real-time filtering publish their average as the real-time value.
// R11: That filtered real-time value updates at 50 Hz regardless of the record rate.
// R12: Unlogged flagged channels still refresh their real-time value at 50 Hz.
// R13: Other channels pass the raw sample to the real-time value.
// R14: All channels of one rate share the same half-period averaging delay.
// R15: Records go to non-volatile flash storage through the write port.
// R16: Capacity is 250 MB, or 500 MB with the upgrade bit set.
// R17: Recording events come from per-channel dividers of a common 1000 per second tick.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
module data_logging_controller
    import data_logging_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Avalon-MM slave
    input  wire logic [7:0]         address,
    input  wire logic               read,
    input  wire logic               write,
    input  wire logic [31:0]        writedata,
    output logic      [31:0]        readdata,
    output logic                    waitrequest,
    output logic                    irq,
    // Channel samples
    input  wire sample_t            sampleIn [NUM_CH],
    output sample_t                 rtOut    [NUM_CH],
    // Flash write port
    output flashwr_t                flashWr,
    input  wire logic               flashReady
);

    // ***************************************************************
    // Registers
    // ***************************************************************
    logic [4:0]        ctrl_q;
    logic [3:0]        irq_q;
    logic [3:0]        mask_q;
    chcfg_t            cfg_q    [NUM_CH];
    logic [ACC_W-1:0]  acc_q    [NUM_CH];
    logic [DIV_W-1:0]  cnt_q    [NUM_CH];
    logic [DIV_W-1:0]  div_q    [NUM_CH];
    logic              fresh_q  [NUM_CH];
    logic [ACC_W-1:0]  racc_q   [NUM_CH];
    logic [DIV_W-1:0]  rcnt_q   [NUM_CH];
    logic [DATA_W-1:0] last_q   [NUM_CH];
    logic              pend_q   [NUM_CH];
    logic [DATA_W-1:0] pval_q   [NUM_CH];
    logic [ADDR_W-1:0] wptr_q;
    logic              full_q;
    logic              wrapped_q;
    logic [31:0]       tickCnt_q;
    logic [7:0]        rtCnt_q;
    logic              logging_q;
    logic              ack_q;
    logic [31:0]       rdata_q;
    flashwr_t          fw_q;

    // ***************************************************************
    // Decoding
    // ***************************************************************
    function automatic logic isCh(input logic [7:0] a, input logic [7:0] base);
        return (a >= base) && (a < base + 8'(NUM_CH * 4));
    endfunction

    wire logic        access   = read | write;
    // Writes commit at the edge that sees waitrequest low, never earlier
    wire logic        wrStb    = write & ack_q;
    wire logic        rdStb    = read & ~ack_q;
    wire logic [1:0]  chIdx    = address[3:2];
    wire logic        selCh    = isCh(address, REG_CH_BASE);
    wire logic        selRt    = isCh(address, REG_RT_BASE);
    wire logic        tick     = (tickCnt_q == 32'(TICK_CYCLES - 1));
    wire logic        rtTick   = tick && (rtCnt_q == 8'(RT_TICKS - 1));
    wire logic        runCond  = ctrl_q[CTRL_START] & ~ctrl_q[CTRL_STOP]; // see R1
    wire logic [ADDR_W-1:0] cap = ctrl_q[CTRL_UPGRD] ? CAP_UPGRD_BYTES
                                                     : CAP_BASE_BYTES; // see R16
    wire logic        atEnd    = (wptr_q + REC_BYTES) >= cap;
    wire logic        canWrite = logging_q & ~full_q;

    // One ack cycle per access: waitrequest drops in the second cycle
    assign waitrequest = access & ~ack_q;
    assign readdata    = rdata_q;
    assign irq         = |(irq_q & mask_q);
    assign flashWr     = fw_q;

    // Record selection: lowest pending channel wins, one per cycle
    logic [1:0] selIdx;
    logic       anyPend;
    always_comb begin
        selIdx  = 2'h0;
        anyPend = 1'b0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                selIdx  = 2'(i);
                anyPend = 1'b1;
            end
        end
    end
    wire logic issue = anyPend & canWrite & (~fw_q.valid | flashReady) & ~ctrl_q[CTRL_CLEAR];

    // ***************************************************************
    // Bus slave
    // ***************************************************************
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        if (address == REG_CTRL)
            rdMux = {27'h0, ctrl_q};
        else if (address == REG_STATUS)
            rdMux = {28'h0, wrapped_q, full_q, logging_q, runCond};
        else if (address == REG_IRQ)
            rdMux = {28'h0, irq_q};
        else if (address == REG_MASK)
            rdMux = {28'h0, mask_q};
        else if (address == REG_WPTR)
            rdMux = {2'h0, wptr_q};
        else if (selCh)
            rdMux = {cfg_q[chIdx].en, cfg_q[chIdx].filt, cfg_q[chIdx].bits,
                     cfg_q[chIdx].rtFilt, 12'h000, cfg_q[chIdx].div};
        else if (selRt)
            rdMux = {16'h0000, rtOut[chIdx].data};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= access & ~ack_q;
            rdata_q <= rdMux;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= 5'h00;
            mask_q <= MASK_RESET;
        end else if (wrStb && address == REG_CTRL) begin
            ctrl_q <= writedata[4:0];
        end else if (wrStb && address == REG_MASK) begin
            mask_q <= writedata[3:0];
        end else begin
            ctrl_q[CTRL_CLEAR] <= 1'b0;
        end
    end

    // ***************************************************************
    // Interrupts: set wins over the clearing read
    // ***************************************************************
    logic [3:0] evt;
    assign evt[EV_FULL]  = issue & atEnd & ~ctrl_q[CTRL_CYCLIC];
    assign evt[EV_WRAP]  = issue & atEnd & ctrl_q[CTRL_CYCLIC];
    assign evt[EV_START] = runCond & ~logging_q;
    assign evt[EV_STOP]  = ~runCond & logging_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            irq_q <= 4'h0;
        else if (rdStb && address == REG_IRQ)
            irq_q <= evt;
        else
            irq_q <= irq_q | evt;
    end

    // ***************************************************************
    // Timebase
    // ***************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tickCnt_q <= 32'h0000_0000;
            rtCnt_q   <= 8'h00;
        end else begin
            tickCnt_q <= tick ? 32'h0000_0000 : tickCnt_q + 32'h0000_0001; // see R17
            if (tick)
                rtCnt_q <= (rtCnt_q == 8'(RT_TICKS - 1)) ? 8'h00 : rtCnt_q + 8'h01;
        end
    end

    // ***************************************************************
    // Logging state and storage pointer
    // ***************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            logging_q <= 1'b0;
            wptr_q    <= 30'h0000_0000;
            full_q    <= 1'b0;
            wrapped_q <= 1'b0;
            fw_q      <= '0;
        end else begin
            logging_q <= runCond; // see R1
            if (fw_q.valid && flashReady)
                fw_q.valid <= 1'b0;
            if (ctrl_q[CTRL_CLEAR]) begin
                wptr_q    <= 30'h0000_0000;
                full_q    <= 1'b0;
                wrapped_q <= 1'b0;
            end else if (issue) begin
                // Record word: channel in bits 17:16, value in low half
                fw_q <= '{valid: 1'b1, addr: wptr_q,
                          data: {14'h0000, selIdx, pval_q[selIdx]}}; // see R15
                if (atEnd) begin
                    wptr_q <= 30'h0000_0000;
                    if (ctrl_q[CTRL_CYCLIC])
                        wrapped_q <= 1'b1; // see R2
                    else
                        full_q <= 1'b1; // see R2
                end else begin
                    wptr_q <= wptr_q + REC_BYTES;
                end
            end
        end
    end

    // ***************************************************************
    // Per-channel dividers, averaging and real-time values
    // ***************************************************************
    for (genvar g = 0; g < NUM_CH; g++) begin : gCh
        // Bit-field channels never average, whatever the filter bit says
        wire logic useAvg = cfg_q[g].filt & ~cfg_q[g].bits; // see R9
        wire logic logEv  = tick && cnt_q[g] == 16'h0000 && cfg_q[g].en; // see R4
        wire logic hasNew = fresh_q[g] || sampleIn[g].valid; // see R5
        wire logic [ACC_W-1:0] accIn  = acc_q[g] + ACC_W'(sampleIn[g].data);
        wire logic [DIV_W-1:0] nIn    = div_q[g] + 16'h0001;
        wire logic [ACC_W-1:0] raccIn = racc_q[g] + ACC_W'(sampleIn[g].data);
        wire logic [DIV_W-1:0] rnIn   = rcnt_q[g] + 16'h0001;
        wire logic [ACC_W-1:0] sumL   = sampleIn[g].valid ? accIn : acc_q[g];
        wire logic [DIV_W-1:0] nL     = sampleIn[g].valid ? nIn : div_q[g];
        wire logic [ACC_W-1:0] sumR   = sampleIn[g].valid ? raccIn : racc_q[g];
        wire logic [DIV_W-1:0] nR     = sampleIn[g].valid ? rnIn : rcnt_q[g];
        // Division is costly but keeps the mean exact; two dividers per channel, one for the record mean and one for the real-time mean
        wire logic [DATA_W-1:0] meanL = (nL == 16'h0000) ? last_q[g]
                                      : DATA_W'(sumL / ACC_W'(nL)); // see R7
        wire logic [DATA_W-1:0] meanR = (nR == 16'h0000) ? rtOut[g].data
                                      : DATA_W'(sumR / ACC_W'(nR));
        wire logic [DATA_W-1:0] rawV  = sampleIn[g].valid ? sampleIn[g].data : last_q[g];

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                cfg_q[g] <= '{en: CH_RESET[CH_EN], filt: CH_RESET[CH_FILT],
                              bits: CH_RESET[CH_BITS], rtFilt: CH_RESET[CH_RTFILT],
                              div: CH_RESET[DIV_W-1:0]}; // see R8
            end else if (wrStb && selCh && chIdx == 2'(g)) begin
                cfg_q[g] <= '{en: writedata[CH_EN], filt: writedata[CH_FILT],
                              bits: writedata[CH_BITS], rtFilt: writedata[CH_RTFILT],
                              div: writedata[DIV_W-1:0]}; // see R6
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                cnt_q[g]   <= 16'h0000;
                acc_q[g]   <= 32'h0000_0000;
                div_q[g]   <= 16'h0000;
                fresh_q[g] <= 1'b0;
                last_q[g]  <= 16'h0000;
                pend_q[g]  <= 1'b0;
                pval_q[g]  <= 16'h0000;
            end else begin
                if (sampleIn[g].valid)
                    last_q[g] <= sampleIn[g].data;
                // Same divider, same tick: equal-rate channels share one delay
                if (tick)
                    cnt_q[g] <= (cnt_q[g] == 16'h0000) ? cfg_q[g].div
                                                       : cnt_q[g] - 16'h0001; // see R14
                if (logEv) begin
                    acc_q[g]   <= 32'h0000_0000;
                    div_q[g]   <= 16'h0000;
                    fresh_q[g] <= 1'b0;
                    if (hasNew && logging_q) begin
                        pend_q[g] <= 1'b1; // see R5
                        pval_q[g] <= useAvg ? meanL : rawV; // see R7
                    end
                end else if (!cfg_q[g].en) begin
                    // Samples from before a channel joins the list never reach its mean
                    acc_q[g]   <= 32'h0000_0000;
                    div_q[g]   <= 16'h0000;
                    fresh_q[g] <= 1'b0;
                end else begin
                    acc_q[g]   <= sumL;
                    div_q[g]   <= nL;
                    fresh_q[g] <= hasNew;
                end
                // Channel select lags pend by nothing: cleared as it issues
                if (issue && selIdx == 2'(g) && !(logEv && hasNew && logging_q))
                    pend_q[g] <= 1'b0;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                racc_q[g] <= 32'h0000_0000;
                rcnt_q[g] <= 16'h0000;
                rtOut[g]  <= '0;
            end else if (cfg_q[g].rtFilt && !cfg_q[g].bits) begin
                // Filtered real-time value refreshed at 50 Hz, logged or not
                if (rtTick) begin
                    racc_q[g] <= 32'h0000_0000;
                    rcnt_q[g] <= 16'h0000;
                    rtOut[g]  <= '{valid: 1'b1, data: meanR}; // see R10 R11 R12
                end else begin
                    racc_q[g] <= sumR;
                    rcnt_q[g] <= nR;
                    rtOut[g].valid <= 1'b0;
                end
            end else begin
                racc_q[g] <= 32'h0000_0000;
                rcnt_q[g] <= 16'h0000;
                rtOut[g]  <= sampleIn[g]; // see R13
            end
        end
    end

endmodule

//--- tb/data_logging_controller_sva.sv
module data_logging_controller_sva
    import data_logging_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register bus
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        irq,
    // Flash port
    input wire flashwr_t    flashWr,
    input wire logic        flashReady
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ********
    // Helpers
    // ********
    logic [ADDR_W-1:0] nextAddr_q;
    logic              seenRec_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nextAddr_q <= '0;
            seenRec_q <= 1'b0;
        end else if (flashWr.valid && flashReady) begin
            nextAddr_q <= flashWr.addr + REC_BYTES;
            seenRec_q <= 1'b1;
        end
    end

    sequence s_reqRise;
        $rose(read || write);
    endsequence
    sequence s_answer;
        waitrequest ##1 !waitrequest;
    endsequence
    sequence s_stopWrite;
        write && !waitrequest && address == REG_CTRL && writedata[CTRL_STOP];
    endsequence
    property p_flashStep;
        flashWr.valid && seenRec_q && !($past(flashWr.valid) && !$past(flashReady))
            |-> flashWr.addr == nextAddr_q || flashWr.addr == '0;
    endproperty

    // ********
    // Checks
    // ********
    a_wait_answer: assert property (s_reqRise |-> s_answer)
        else $error("bus access not answered on the second cycle");
    a_reset_quiet: assert property (disable iff (1'b0) rst && $past(rst) |-> !irq && !flashWr.valid)
        else $error("outputs active during reset");
    a_read_unmapped: assert property (read && !waitrequest && address >= 8'h50 |-> readdata == '0)
        else $error("unmapped read returned data");
    a_irq_masked: assert property (write && !waitrequest && address == REG_MASK
            && writedata[3:0] == 4'h0 |=> !irq)
        else $error("interrupt high with all sources masked");
    a_flash_hold: assert property (flashWr.valid && !flashReady |=> flashWr.valid && $stable(flashWr))
        else $error("flash record changed before acceptance");
    a_record_fmt: assert property (flashWr.valid |-> flashWr.data[31:18] == 14'h0)
        else $error("flash record upper bits not zero");
    a_flash_step: assert property (p_flashStep)
        else $error("flash address did not step by one record");
    a_stop_quiet: assert property (s_stopWrite |-> ##3 (!$rose(flashWr.valid)) [*8])
        else $error("new record after stop condition");
endmodule

bind data_logging_controller data_logging_controller_sva data_logging_controller_sva_i (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .flashWr(flashWr), .flashReady(flashReady));

//--- tb/flash_store_model.sv
module flash_store_model
    import data_logging_pkg::*;
(
    // Clock
    input wire logic clk,
    // Write port
    input wire flashwr_t flashWr,
    output logic         flashReady
);
    timeunit 1ns;
    timeprecision 1ps;
    // Contents survive reset, as flash keeps data without power
    logic [31:0] mem [int];
    int          count = 0;
    initial begin
        flashReady = 1'b0;
        forever begin
            @(posedge clk);
            if (flashWr.valid && flashReady) begin
                mem[int'(flashWr.addr)] = flashWr.data;
                count++;
            end
            // Random stalls: a slow erase or program is legal for flash
            flashReady <= ($urandom_range(3, 0) != 0);
        end
    end
endmodule

//--- tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import data_logging_pkg::*;
    logic        clk;
    logic        rst;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        irq;
    logic        flashReady;
    logic [31:0] q;
    logic [3:0]  got;
    sample_t     sampleIn [NUM_CH];
    sample_t     rtOut [NUM_CH];
    flashwr_t    flashWr;
    logic [15:0] lastVal [NUM_CH];
    int          err_total = 0;
    int          num_checks = 0;
    int          n;

    data_logging_controller data_logging_controller_i (.clk(clk), .rst(rst),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .sampleIn(sampleIn), .rtOut(rtOut), .flashWr(flashWr), .flashReady(flashReady));
    flash_store_model flash_store_model_i (.clk(clk), .flashWr(flashWr),
        .flashReady(flashReady));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ********
    // Tasks
    // ********
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic w;
        int   k;
        k = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            #1;
            w = waitrequest;
            q = readdata;
            @(posedge clk);
            k++;
        end while (w !== 1'b0 && k < 50);
        read <= 1'b0;
        write <= 1'b0;
        if (k >= 50) begin
            chk("bus answer", 32'h0, 32'h1);
            conclude();
        end
    endtask

    task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, q & m, exp);
    endtask

    task automatic drive(input int ch, input logic [15:0] v);
        @(posedge clk);
        sampleIn[ch] <= '{valid: 1'b1, data: v};
        lastVal[ch] = v;
        @(posedge clk);
        sampleIn[ch].valid <= 1'b0;
        #1;
        chk("raw realtime", 32'(rtOut[ch]), {15'h0, 1'b1, v});
    endtask

    task automatic waitIrq();
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 20) begin
            chk("irq wait", 32'h0, 32'h1);
            conclude();
        end
    endtask

    // Channel 1 is fed a constant, so any average of it is that constant
    function automatic logic [31:0] expRec(input logic [1:0] ch);
        if (ch == 2'h1) return {14'h0, ch, 16'h1234};
        if (ch == 2'h3) return 32'hFFFF_FFFF;
        return {14'h0, ch, lastVal[ch]};
    endfunction

    // ********
    // Sequence
    // ********
    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        foreach (sampleIn[i]) sampleIn[i] = '0;
        void'($urandom(32'hB01F));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdChk("ctrl reset", REG_CTRL, 32'hFFFF_FFFF, 32'h0);
        rdChk("mask reset", REG_MASK, 32'hF, {28'h0, MASK_RESET});
        rdChk("wptr reset", REG_WPTR, 32'hFFFF_FFFF, 32'h0);
        for (int c = 0; c < NUM_CH; c++) begin
            rdChk("channel reset", REG_CH_BASE + 8'(4 * c), 32'hFFFF_FFFF, CH_RESET);
        end
        bus(1'b1, 8'h50, 32'hFFFF_FFFF);
        rdChk("unmapped", 8'h50, 32'hFFFF_FFFF, 32'h0);
        bus(1'b1, REG_STATUS, 32'hF);
        rdChk("status read only", REG_STATUS, 32'hF, 32'h0);
        $display("reset and map test done");
        for (int i = 0; i < 4 * NUM_CH; i++) begin
            drive(i % NUM_CH, 16'($urandom));
        end
        for (int c = 0; c < NUM_CH; c++) begin
            rdChk("realtime reg", REG_RT_BASE + 8'(4 * c), 32'hFFFF, {16'h0, lastVal[c]});
        end
        $display("realtime test done");
        bus(1'b1, REG_MASK, 32'hF);
        bus(1'b1, REG_CTRL, 32'h5);
        waitIrq();
        chk("irq on start", 32'(irq), 32'h1);
        rdChk("logging", REG_STATUS, 32'h3, 32'h3);
        rdChk("start event", REG_IRQ, 32'hC, 32'h1 << EV_START);
        rdChk("event cleared", REG_IRQ, 32'hC, 32'h0);
        chk("irq cleared", 32'(irq), 32'h0);
        bus(1'b1, REG_CTRL, 32'h7);
        waitIrq();
        rdChk("stopped", REG_STATUS, 32'h2, 32'h0);
        rdChk("stop event", REG_IRQ, 32'hC, 32'h1 << EV_STOP);
        bus(1'b1, REG_MASK, 32'h0);
        bus(1'b1, REG_CTRL, 32'h5);
        repeat (4) @(posedge clk);
        #1;
        chk("masked irq", 32'(irq), 32'h0);
        rdChk("masked event", REG_IRQ, 32'hC, 32'h1 << EV_START);
        $display("start stop test done");
        bus(1'b1, REG_CTRL, 32'h15);
        bus(1'b1, REG_CH_BASE, 32'h8000_0000);
        bus(1'b1, REG_CH_BASE + 8'h04, 32'hC000_0000);
        bus(1'b1, REG_CH_BASE + 8'h08, 32'hE000_0000);
        bus(1'b1, REG_CH_BASE + 8'h0C, 32'hC000_0000);
        rdChk("filter off", REG_CH_BASE, 32'hF000_FFFF, 32'h8000_0000);
        // One tick is a long wait; steady values, as the tick may fall between drives
        n = 0;
        while (flash_store_model_i.count < 3 && n < 1500) begin
            drive(0, lastVal[0]);
            drive(1, 16'h1234);
            drive(2, lastVal[2]);
            repeat (90) @(posedge clk);
            n++;
        end
        chk("record count", 32'(flash_store_model_i.count), 32'h3);
        got = 4'h0;
        for (int k = 0; k < 3; k++) begin
            q = flash_store_model_i.mem.exists(4 * k) ? flash_store_model_i.mem[4 * k] : 32'h0;
            chk("record", q, expRec(q[17:16]));
            got[q[17:16]] = 1'b1;
        end
        chk("channels recorded", {28'h0, got}, 32'h7);
        rdChk("write pointer", REG_WPTR, 32'hFFFF_FFFF, 32'(3 * REC_BYTES));
        $display("recording test done");
        conclude();
    end
endmodule
